// *** elr_pkg.sv ***
package elr_pkg;
    // ------------------------------------------------------------
    // Build dimensions
    // ------------------------------------------------------------
    localparam int NUM_SRC = 189;        // Source event lines, numbered 1..189
    localparam int NUM_SLOT = 46;        // Slot index space 0..45
    localparam int SEL_W = 8;            // Selection field width
    localparam int ADDR_W = 8;           // Register address width
    localparam int DATA_W = 8;           // Register data width

    // ------------------------------------------------------------
    // Selection codes
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_OFF = 8'h00;       // Link disabled
    localparam logic [7:0] SEL_MIN_FULL = 8'h01;  // 189-source build lowest code
    localparam logic [7:0] SEL_MAX_FULL = 8'hbd;  // 189-source build highest code
    localparam logic [7:0] SEL_MIN_SMALL = 8'h08; // 99-source build lowest code
    localparam logic [7:0] SEL_MAX_SMALL = 8'h6a; // 99-source build highest code

    // ------------------------------------------------------------
    // Implemented slots: one bit per slot index
    // ------------------------------------------------------------
    localparam logic [45:0] SLOT_MAP = 46'h207a_1ffd_bc99;

    // ------------------------------------------------------------
    // Register offsets (selection n sits at SEL_BASE + n)
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_BASE = 8'h00;
    localparam logic [7:0] OFS_OPT_A = 8'h40;
    localparam logic [7:0] OFS_OPT_C = 8'h41;
    localparam logic [7:0] OFS_OPT_D = 8'h42;
    localparam logic [7:0] OFS_OPT_F = 8'h43;
    localparam logic [7:0] OFS_OPT_H = 8'h44;
    localparam logic [7:0] OFS_PORT_CTL = 8'h48;
    localparam logic [7:0] OFS_GRP_MASK = 8'h49;
    localparam logic [7:0] OFS_STOP = 8'h4a;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int OPA_T0_LSB = 0;       // Timer 0 action in option A
    localparam int OPA_T1_LSB = 2;       // Timer 1 action in option A
    localparam int OPA_T2_LSB = 4;       // Timer 2 action in option A
    localparam int OPC_LPT_LSB = 0;      // Low-power timer action in option C
    localparam int OPD_T1_LSB = 2;       // 8-bit timer 1 action in option D
    localparam int OPD_T3_LSB = 6;       // 8-bit timer 3 action in option D
    localparam int PC_PIN_LSB = 0;       // Single-port pin number, 3 bits
    localparam int PC_PORT_BIT = 3;      // 0 = port B, 1 = port E
    localparam int PC_GROUP_BIT = 4;     // 0 = single pin, 1 = pin group
    localparam logic [7:0] RST_VAL = 8'h00;

    // ------------------------------------------------------------
    // Port-link slots
    // ------------------------------------------------------------
    localparam int SLOT_PORT_SINGLE = 24; // Drives the port-link output
endpackage

// *** elr_slot.sv ***
`timescale 1ns/10ps
// Forwards one chosen source event to one receiving slot as a pulse
module elr_slot #(
    parameter int NUM_SRC = elr_pkg::NUM_SRC,
    parameter logic [7:0] SEL_MIN = elr_pkg::SEL_MIN_FULL,
    parameter logic [7:0] SEL_MAX = elr_pkg::SEL_MAX_FULL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [7:0] sel,
    // Events
    input wire logic [NUM_SRC:1] src_rise,
    output logic pulse
);
    // ------------------------------------------------------------
    // Source pick
    // ------------------------------------------------------------
    logic next_pulse; // Picked source edge, gated by code range

    // Out-of-range codes give no event rather than an alias
    always_comb begin
        next_pulse = 1'b0;
        if (run && sel != elr_pkg::SEL_OFF && sel >= SEL_MIN && sel <= SEL_MAX) begin
            if (32'(sel) <= NUM_SRC) begin
                next_pulse = src_rise[sel];
            end
        end
    end

    // Registered one-cycle pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= next_pulse;
        end
    end
endmodule

// *** elr_event_link_router.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Route any source event to a slot
// - Zero selection disables the slot output
// - Nonzero code names the forwarded source event
// - Small build: 99 sources, narrower code range
// - Only the listed slot indices exist
// - Two-bit field picks each timer's action
// - Port link on port B or E only
// - Single-port mode drives one chosen pin
// - Group mode drives masked pins of eight
// - Module stop halts routing to save power
module elr_event_link_router #(
    parameter bit SMALL_BUILD = 1'b0,
    parameter int NUM_SRC = elr_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register port
    input wire logic [elr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [elr_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [elr_pkg::DATA_W-1:0] RDATA,
    // Source events, levels from other peripherals
    input wire logic [NUM_SRC:1] EVENT_IN,
    // Receiving slots, one pulse bit per slot index
    output logic [elr_pkg::NUM_SLOT-1:0] SLOT_EVENT,
    // Timer actions
    output logic [1:0] TIMER0_EVENT_ACTION,
    output logic [1:0] TIMER1_EVENT_ACTION,
    output logic [1:0] TIMER2_EVENT_ACTION,
    output logic [1:0] LOWPOWER_TIMER_EVENT_ACTION,
    output logic [1:0] EIGHTBIT_TIMER1_EVENT_ACTION,
    output logic [1:0] EIGHTBIT_TIMER3_EVENT_ACTION,
    // Option registers with no decoded meaning here
    output logic [7:0] OPTION_REG_F,
    output logic [7:0] OPTION_REG_H,
    // Port link pulses
    output logic [7:0] PORTB_EVENT,
    output logic [7:0] PORTE_EVENT
);
    // ------------------------------------------------------------
    // Build constants
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_MIN = SMALL_BUILD ? elr_pkg::SEL_MIN_SMALL
                                                 : elr_pkg::SEL_MIN_FULL;
    localparam logic [7:0] SEL_MAX = SMALL_BUILD ? elr_pkg::SEL_MAX_SMALL
                                                 : elr_pkg::SEL_MAX_FULL;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] event_link_select_n [elr_pkg::NUM_SLOT]; // Per-slot source code
    logic [7:0] timer_option_a; // Timer 0..2 actions
    logic [7:0] timer_option_c; // Low-power timer action
    logic [7:0] timer_option_d; // 8-bit timer actions
    logic [7:0] option_reg_f; // Held, passed through
    logic [7:0] option_reg_h; // Held, passed through
    logic [7:0] port_ctl; // Port link mode, port, pin
    logic [7:0] group_mask; // Pins joined in group mode
    logic module_stop; // High stops routing

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [NUM_SRC:1] ev_meta; // First stage, read only by ev_sync
    logic [NUM_SRC:1] ev_sync; // Second stage
    logic [NUM_SRC:1] ev_last; // For edge detection
    logic [NUM_SRC:1] ev_rise; // Detected event edges

    // Events come from peripherals that may run on other clocks
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ev_meta <= '0;
            ev_sync <= '0;
            ev_last <= '0;
        end else begin
            ev_meta <= EVENT_IN;
            ev_sync <= ev_meta;
            ev_last <= ev_sync;
        end
    end

    // Stopped module sees no edges at all
    assign ev_rise = module_stop ? '0 : (ev_sync & ~ev_last);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic sel_hit; // Address falls in selection window
    logic [7:0] sel_idx; // Slot index of that address

    assign sel_idx = ADDR - elr_pkg::SEL_BASE;
    assign sel_hit = (ADDR >= elr_pkg::SEL_BASE) && (32'(sel_idx) < elr_pkg::NUM_SLOT);

    // Selection registers; absent slots stay zero and ignore writes
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            for (int i = 0; i < elr_pkg::NUM_SLOT; i++) begin
                event_link_select_n[i] <= elr_pkg::RST_VAL;
            end
        end else if (WR && sel_hit && elr_pkg::SLOT_MAP[sel_idx[5:0]]) begin
            // Software is trusted to write only legal codes
            event_link_select_n[sel_idx[5:0]] <= WDATA;
        end
    end

    // Timer option registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            timer_option_a <= elr_pkg::RST_VAL;
            timer_option_c <= elr_pkg::RST_VAL;
            timer_option_d <= elr_pkg::RST_VAL;
            option_reg_f <= elr_pkg::RST_VAL;
            option_reg_h <= elr_pkg::RST_VAL;
        end else if (WR) begin
            case (ADDR)
                elr_pkg::OFS_OPT_A: begin
                    timer_option_a <= WDATA;
                end
                elr_pkg::OFS_OPT_C: begin
                    timer_option_c <= WDATA;
                end
                elr_pkg::OFS_OPT_D: begin
                    timer_option_d <= WDATA;
                end
                elr_pkg::OFS_OPT_F: begin
                    option_reg_f <= WDATA;
                end
                elr_pkg::OFS_OPT_H: begin
                    option_reg_h <= WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    // Port link and module stop controls
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            port_ctl <= elr_pkg::RST_VAL;
            group_mask <= elr_pkg::RST_VAL;
            module_stop <= 1'b0;
        end else if (WR) begin
            case (ADDR)
                elr_pkg::OFS_PORT_CTL: begin
                    port_ctl <= WDATA;
                end
                elr_pkg::OFS_GRP_MASK: begin
                    group_mask <= WDATA;
                end
                elr_pkg::OFS_STOP: begin
                    module_stop <= WDATA[0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    logic [7:0] next_rdata; // Read value, registered next cycle

    // Unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (sel_hit) begin
            next_rdata = event_link_select_n[sel_idx[5:0]];
        end else begin
            case (ADDR)
                elr_pkg::OFS_OPT_A: next_rdata = timer_option_a;
                elr_pkg::OFS_OPT_C: next_rdata = timer_option_c;
                elr_pkg::OFS_OPT_D: next_rdata = timer_option_d;
                elr_pkg::OFS_OPT_F: next_rdata = option_reg_f;
                elr_pkg::OFS_OPT_H: next_rdata = option_reg_h;
                elr_pkg::OFS_PORT_CTL: next_rdata = port_ctl;
                elr_pkg::OFS_GRP_MASK: next_rdata = group_mask;
                elr_pkg::OFS_STOP: next_rdata = {7'h00, module_stop};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Slot routing
    // ------------------------------------------------------------
    logic [elr_pkg::NUM_SLOT-1:0] slot_pulse; // Pulses from every slot

    // Only implemented slots get routing logic
    for (genvar s = 0; s < elr_pkg::NUM_SLOT; s++) begin : g_slot
        if (elr_pkg::SLOT_MAP[s]) begin : g_on
            elr_slot #(
                .NUM_SRC(NUM_SRC),
                .SEL_MIN(SEL_MIN),
                .SEL_MAX(SEL_MAX)
            ) u_slot (
                .clk(CLK),
                .nrst(NRST),
                .run(!module_stop),
                .sel(event_link_select_n[s]),
                .src_rise(ev_rise),
                .pulse(slot_pulse[s])
            );
        end else begin : g_off
            assign slot_pulse[s] = 1'b0;
        end
    end

    assign SLOT_EVENT = slot_pulse;

    // ------------------------------------------------------------
    // Timer action outputs
    // ------------------------------------------------------------
    assign TIMER0_EVENT_ACTION = timer_option_a[elr_pkg::OPA_T0_LSB +: 2];
    assign TIMER1_EVENT_ACTION = timer_option_a[elr_pkg::OPA_T1_LSB +: 2];
    assign TIMER2_EVENT_ACTION = timer_option_a[elr_pkg::OPA_T2_LSB +: 2];
    assign LOWPOWER_TIMER_EVENT_ACTION = timer_option_c[elr_pkg::OPC_LPT_LSB +: 2];
    assign EIGHTBIT_TIMER1_EVENT_ACTION = timer_option_d[elr_pkg::OPD_T1_LSB +: 2];
    assign EIGHTBIT_TIMER3_EVENT_ACTION = timer_option_d[elr_pkg::OPD_T3_LSB +: 2];
    assign OPTION_REG_F = option_reg_f;
    assign OPTION_REG_H = option_reg_h;

    // ------------------------------------------------------------
    // Port link
    // ------------------------------------------------------------
    logic [7:0] pin_mask; // Pins that receive the port event
    logic use_port_e; // Chosen port

    assign use_port_e = port_ctl[elr_pkg::PC_PORT_BIT];

    // Mode picks one pin or the masked group
    always_comb begin
        pin_mask = 8'h00;
        if (port_ctl[elr_pkg::PC_GROUP_BIT]) begin
            pin_mask = group_mask;
        end else begin
            pin_mask[port_ctl[elr_pkg::PC_PIN_LSB +: 3]] = 1'b1;
        end
    end

    // Registered so port outputs come from flip-flops
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            PORTB_EVENT <= 8'h00;
            PORTE_EVENT <= 8'h00;
        end else begin
            // Adds one cycle over the slot pulse; kept for clean pin timing
            PORTB_EVENT <= (slot_pulse[elr_pkg::SLOT_PORT_SINGLE] && !use_port_e)
                           ? pin_mask : 8'h00;
            PORTE_EVENT <= (slot_pulse[elr_pkg::SLOT_PORT_SINGLE] && use_port_e)
                           ? pin_mask : 8'h00;
        end
    end
endmodule

// *** elr_chk.sv ***
`timescale 1ns/10ps
module elr_chk (
    // Clock, reset and register port
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic [7:0] RDATA,
    // Outputs under watch
    input wire logic [45:0] SLOT_EVENT,
    input wire logic [1:0] TIMER0_EVENT_ACTION,
    input wire logic [7:0] PORTB_EVENT,
    input wire logic [7:0] PORTE_EVENT
);
    // ------------
    // Mirrors of port mode, group mask and stop
    // ------------
    logic [7:0] ctl; // Port link control copy
    logic [7:0] msk; // Group mask copy
    logic stp; // Module stop copy
    logic [7:0] pins; // Pin pulses of either port
    assign pins = PORTB_EVENT | PORTE_EVENT;
    // Follows register writes so mode checks need no access to internals
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctl <= 8'h00;
            msk <= 8'h00;
            stp <= 1'b0;
        end else if (WR) begin
            if (ADDR == elr_pkg::OFS_PORT_CTL) ctl <= WDATA;
            if (ADDR == elr_pkg::OFS_GRP_MASK) msk <= WDATA;
            if (ADDR == elr_pkg::OFS_STOP) stp <= WDATA[0];
        end
    end
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Five stopped cycles flush any pulse already in the pipeline
    sequence s_stop; stp [*5]; endsequence
    sequence s_feed; SLOT_EVENT[elr_pkg::SLOT_PORT_SINGLE] && !stp && !ctl[4]; endsequence
    property p_pulse; (SLOT_EVENT & $past(SLOT_EVENT)) == '0; endproperty
    property p_absent; (SLOT_EVENT & ~elr_pkg::SLOT_MAP) == '0; endproperty
    // Reset must be checked while reset is low, so no disable here
    property p_reset;
        disable iff (1'b0) !NRST |=> RDATA == 8'h00 && SLOT_EVENT == '0 && pins == 8'h00
            && TIMER0_EVENT_ACTION == 2'b00;
    endproperty
    property p_action;
        $changed(TIMER0_EVENT_ACTION) |-> $past(WR) && $past(ADDR) == elr_pkg::OFS_OPT_A;
    endproperty
    property p_stop; s_stop |-> SLOT_EVENT == '0 && pins == 8'h00; endproperty
    property p_port_src; pins != 8'h00 |-> $past(SLOT_EVENT[elr_pkg::SLOT_PORT_SINGLE]); endproperty
    property p_port_go; s_feed |=> pins != 8'h00; endproperty
    property p_side; !(PORTB_EVENT != 8'h00 && PORTE_EVENT != 8'h00); endproperty
    property p_single; !ctl[4] |-> $onehot0(pins); endproperty
    property p_group; ctl[4] |-> (pins & ~msk) == 8'h00; endproperty
    a_pulse: assert property (p_pulse) else $error("slot pulse too long");
    a_absent: assert property (p_absent) else $error("absent slot pulsed");
    a_reset: assert property (p_reset) else $error("output not cleared by reset");
    a_action: assert property (p_action) else $error("action moved without write");
    a_stop: assert property (p_stop) else $error("pulse while stopped");
    a_port_src: assert property (p_port_src) else $error("pin pulse without slot");
    a_port_go: assert property (p_port_go) else $error("slot pulse lost at pin");
    a_side: assert property (p_side) else $error("both ports pulsed");
    a_single: assert property (p_single) else $error("several pins in single mode");
    a_group: assert property (p_group) else $error("unmasked pin pulsed");
endmodule

bind elr_event_link_router elr_chk u_chk (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RDATA(RDATA),
    .SLOT_EVENT(SLOT_EVENT), .TIMER0_EVENT_ACTION(TIMER0_EVENT_ACTION),
    .PORTB_EVENT(PORTB_EVENT), .PORTE_EVENT(PORTE_EVENT)
);

// *** elr_src_model.sv ***
`timescale 1ns/10ps
// Source peripherals: each request raises one event level for a while
module elr_src_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Request from the bench
    input wire logic go,
    input wire logic [7:0] num,
    // Event levels toward the router
    output logic [189:1] ev
);
    logic [2:0] hold; // Cycles left high
    // Held high long enough to pass the synchroniser, then low again
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ev <= '0;
            hold <= 3'h0;
        end else if (go) begin
            ev <= '0;
            ev[num] <= 1'b1;
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end else begin
            ev <= '0;
        end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
    // ------------
    // Stimulus and observed signals
    // ------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0; // Request to the source model
    logic [7:0] num = 8'h00; // Event number to raise
    logic [189:1] ev;
    logic [7:0] rdata, pb, pe, opf, oph;
    logic [45:0] slot;
    logic [45:0] slot_sm; // Slot pulses of the narrow-code build
    logic [1:0] t0, t1, t2, lpt, e1, e3;
    int fails = 0;
    int tests_run = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    elr_src_model u_src (.clk(clk), .nrst(nrst), .go(go), .num(num), .ev(ev));
    elr_event_link_router DUT (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .EVENT_IN(ev), .SLOT_EVENT(slot), .TIMER0_EVENT_ACTION(t0), .TIMER1_EVENT_ACTION(t1),
        .TIMER2_EVENT_ACTION(t2), .LOWPOWER_TIMER_EVENT_ACTION(lpt),
        .EIGHTBIT_TIMER1_EVENT_ACTION(e1), .EIGHTBIT_TIMER3_EVENT_ACTION(e3),
        .OPTION_REG_F(opf), .OPTION_REG_H(oph), .PORTB_EVENT(pb), .PORTE_EVENT(pe)
    );
    // Narrow-code build shares every input; only its slot pulses are compared
    elr_event_link_router #(.SMALL_BUILD(1'b1)) DUT_SMALL (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(),
        .EVENT_IN(ev), .SLOT_EVENT(slot_sm), .TIMER0_EVENT_ACTION(), .TIMER1_EVENT_ACTION(),
        .TIMER2_EVENT_ACTION(), .LOWPOWER_TIMER_EVENT_ACTION(),
        .EIGHTBIT_TIMER1_EVENT_ACTION(), .EIGHTBIT_TIMER3_EVENT_ACTION(),
        .OPTION_REG_F(), .OPTION_REG_H(), .PORTB_EVENT(), .PORTE_EVENT()
    );
    // ------------
    // Shared tasks
    // ------------
    task automatic chk(input string what, input logic [45:0] exp, input logic [45:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), 46'(e), 46'(rdata));
    endtask
    // Raise one event, gather pulses over a window, count pulse cycles
    task automatic fire(input logic [7:0] n, input logic [45:0] es, input logic [7:0] eb,
                        input logic [7:0] ee);
        logic [45:0] s;
        logic [45:0] ss;
        logic [7:0] b, e;
        int hs, hp;
        s = '0;
        ss = '0;
        b = 8'h00;
        e = 8'h00;
        hs = 0;
        hp = 0;
        @(posedge clk);
        go <= 1'b1;
        num <= n;
        repeat (12) begin
            @(posedge clk);
            go <= 1'b0;
            #1;
            s = s | slot;
            ss = ss | slot_sm;
            b = b | pb;
            e = e | pe;
            hs += int'(slot != '0);
            hp += int'((pb | pe) != 8'h00);
        end
        chk("slots", es, s);
        chk("narrow slots", (n >= elr_pkg::SEL_MIN_SMALL && n <= elr_pkg::SEL_MAX_SMALL)
            ? es : 46'h0, ss);
        chk("port b", 46'(eb), 46'(b));
        chk("port e", 46'(ee), 46'(e));
        chk("slot cycles", 46'(es != '0), 46'(hs));
        chk("pin cycles", 46'((eb | ee) != 8'h00), 46'(hp));
    endtask
    task automatic port_case(input logic [7:0] c, input logic [7:0] eb, input logic [7:0] ee);
        wr_reg(elr_pkg::OFS_PORT_CTL, c);
        fire(8'd25, 46'(1) << 24, eb, ee);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------
    // Test sequence
    // ------------
    initial begin
        do_reset();
        for (int n = 0; n < 46; n++) rd_chk(8'(n), 8'h00);
        for (int a = 8'h40; a < 8'h4b; a++) rd_chk(8'(a), 8'h00);
        $display("test reset values done");
        for (int n = 0; n < 46; n++) wr_reg(8'(n), 8'(n + 1));
        for (int n = 0; n < 46; n++) rd_chk(8'(n), elr_pkg::SLOT_MAP[n] ? 8'(n + 1) : 8'h00);
        wr_reg(8'h50, 8'hff);
        rd_chk(8'h50, 8'h00);
        for (int n = 0; n < 46; n++) fire(8'(n + 1), elr_pkg::SLOT_MAP[n] ? 46'(1) << n : '0,
                                          8'(n == 24), 8'h00);
        $display("test slot routing done");
        wr_reg(8'h03, 8'hbd);
        fire(8'hbd, 46'h8, 8'h00, 8'h00);
        wr_reg(8'h03, 8'h01);
        fire(8'h01, 46'h9, 8'h00, 8'h00);
        wr_reg(8'h03, 8'h00);
        fire(8'h04, '0, 8'h00, 8'h00);
        wr_reg(8'h03, 8'h04);
        $display("test code bounds done");
        wr_reg(elr_pkg::OFS_GRP_MASK, 8'ha5);
        port_case(8'h05, 8'h20, 8'h00);
        port_case(8'h0b, 8'h00, 8'h08);
        port_case(8'h10, 8'ha5, 8'h00);
        port_case(8'h18, 8'h00, 8'ha5);
        $display("test port link done");
        wr_reg(elr_pkg::OFS_STOP, 8'h01);
        fire(8'h04, '0, 8'h00, 8'h00);
        rd_chk(elr_pkg::OFS_STOP, 8'h01);
        wr_reg(elr_pkg::OFS_STOP, 8'h00);
        fire(8'h04, 46'h8, 8'h00, 8'h00);
        $display("test module stop done");
        wr_reg(elr_pkg::OFS_OPT_A, 8'h39);
        wr_reg(elr_pkg::OFS_OPT_C, 8'h02);
        wr_reg(elr_pkg::OFS_OPT_D, 8'h4c);
        wr_reg(elr_pkg::OFS_OPT_F, 8'h5a);
        wr_reg(elr_pkg::OFS_OPT_H, 8'hc3);
        rd_chk(elr_pkg::OFS_OPT_D, 8'h4c);
        chk("actions", 46'({t0, t1, t2, lpt, e1, e3, opf, oph}), 46'(28'h6ed_5ac3));
        $display("test timer actions done");
        do_reset();
        rd_chk(elr_pkg::OFS_OPT_A, 8'h00);
        rd_chk(8'h03, 8'h00);
        #1;
        chk("actions", 46'({t0, t1, t2, lpt, e1, e3, opf, oph}), '0);
        $display("test second reset done");
        report_and_stop();
    end
    // Whole run needs under 2000 cycles; a hang is cut off well after
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end
endmodule
